// ===== hdl/aaci_pkg.sv
`default_nettype none
package aaci_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int RES_W  = 16;
	localparam int WORD_W = 32;
	localparam int CNT_W  = 6;
	localparam int FLAG_W = 8;
	localparam int HYST_W = 4;
	localparam int PIN_N  = 3;

	// ----------------------------------------
	// Synchronised pin positions
	// ----------------------------------------
	localparam int PIN_CS    = 0;
	localparam int PIN_OVER  = 1;
	localparam int PIN_UNDER = 2;

	// ----------------------------------------
	// Frame and function codes
	// ----------------------------------------
	localparam logic [CNT_W-1:0] FULL_FRAME = 6'h20;
	localparam logic [1:0]       FN_ALARM   = 2'h1;
	localparam int               APP_IN     = 0;
	localparam int               APP_SUP    = 1;

	// ----------------------------------------
	// Alarm flag byte layout
	// ----------------------------------------
	localparam int FL_IN_ACT   = 0;
	localparam int FL_IN_TRIP  = 1;
	localparam int FL_SUP_ACT  = 2;
	localparam int FL_SUP_TRIP = 3;
	localparam int FL_IN_HI    = 4;
	localparam int FL_IN_LO    = 5;
	localparam int FL_SUP_HI   = 6;
	localparam int FL_SUP_LO   = 7;
	localparam logic [FLAG_W-1:0] IN_MASK  = 8'h33;
	localparam logic [FLAG_W-1:0] SUP_MASK = 8'hcc;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [FLAG_W-1:0] FLAGS_RST  = 8'h00;
	localparam logic [PIN_N-1:0]  PIN_RST    = 3'h1;
	localparam logic [WORD_W-1:0] WORD_RST   = 32'h0000_0000;
	localparam logic [RES_W-1:0]  RESULT_RST = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_RST    = 6'h00;

	// Fixed supply comparator trip points, in mV
	localparam int SUP_HI_MV = 5300;
	localparam int SUP_LO_MV = 4700;

	typedef enum logic [1:0] {
		ST_ACQ,
		ST_FRAME,
		ST_CONV,
		ST_LOAD
	} aaci_state_type;

endpackage
`default_nettype wire

// ===== hdl/aaci_link.sv
`timescale 1ns/10ps
`default_nettype none
module aaci_link
	import aaci_pkg::*;
(
	input  wire logic              sclk_i,
	input  wire logic              rst_i,
	input  wire logic              cs_i,
	input  wire logic              sdi_i,
	input  wire logic [WORD_W-1:0] load_word_i,
	output logic      [WORD_W-1:0] shift_word_o,
	output logic      [CNT_W-1:0]  bit_count_o,
	output logic                   serial_o,
	output logic                   serial_oe_o
);

	// ----------------------------------------
	// Frame-scoped state
	// ----------------------------------------
	// Open and launch flops cleared by the select line itself; sclk may stop between frames
	logic frame_rst;
	logic open_ff;
	logic launched_ff;
	logic launch_ff;
	logic [WORD_W-1:0] shreg_ff;
	logic [CNT_W-1:0]  cnt_ff;

	assign frame_rst = rst_i | cs_i;

	always_ff @(posedge sclk_i or posedge frame_rst) begin
		if (frame_rst) begin
			open_ff <= 1'b0;
		end else begin
			open_ff <= 1'b1;
		end
	end

	// ----------------------------------------
	// Capture edge: shift in at the LSB
	// ----------------------------------------
	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			shreg_ff <= WORD_RST;
		end else if (!open_ff) begin
			shreg_ff <= {load_word_i[WORD_W-2:0], sdi_i};
		end else begin
			shreg_ff <= {shreg_ff[WORD_W-2:0], sdi_i};
		end
	end

	// Count saturates so long frames stay long
	always_ff @(posedge sclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff <= CNT_RST;
		end else if (!open_ff) begin
			cnt_ff <= CNT_W'(1);
		end else if (cnt_ff != {CNT_W{1'b1}}) begin
			cnt_ff <= cnt_ff + CNT_W'(1);
		end
	end

	// ----------------------------------------
	// Launch edge: MSB to the output
	// ----------------------------------------
	always_ff @(negedge sclk_i or posedge frame_rst) begin
		if (frame_rst) begin
			launched_ff <= 1'b0;
			launch_ff   <= 1'b0;
		end else begin
			launched_ff <= open_ff;
			launch_ff   <= shreg_ff[WORD_W-1];
		end
	end

	// First bit comes straight from the frozen load word
	assign serial_o     = launched_ff ? launch_ff : load_word_i[WORD_W-1];
	assign serial_oe_o  = ~cs_i;
	assign shift_word_o = shreg_ff;
	assign bit_count_o  = cnt_ff;

endmodule
`default_nettype wire

// ===== hdl/aaci_core.sv
// Summary of operation
// - Results leave as unsigned straight binary
// - Result code is sixteen bits wide
// - Alarm on pin only when function 01b
// - Both alarms on by default, separately disabled
// - Each alarm sets active and tripped flags
// - Active flag recomputed at each conversion end
// - Tripped flag holds until alarm read
// - Flags update at conversion end, read anytime
// - Alarm pin high on either active flag
// - Selected flags appended after the result
// - High alarm sets above high threshold
// - High alarm clears below threshold minus hysteresis
// - Low alarm sets below low threshold
// - Low alarm clears above threshold plus hysteresis
// - Separate thresholds, one shared hysteresis
// - Supply alarms from fixed comparator trips
// - Behaves as one 32-bit shift register
// - MSB out on launch, LSB in on capture
// - Sample on select rise, frame on fall
// - Decode shift register on select rise
`timescale 1ns/10ps
`default_nettype none
module aaci_core
	import aaci_pkg::*;
#(
	parameter int HW = HYST_W
)
(
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	input  wire logic              sclk_i,
	input  wire logic              convert_start_select_i,
	input  wire logic              sdi_i,
	input  wire logic              conv_done_i,
	input  wire logic [RES_W-1:0]  conv_result_i,
	input  wire logic              supply_over_i,
	input  wire logic              supply_under_i,
	input  wire logic [1:0]        secondary_output_function_i,
	input  wire logic              input_alarm_disable_i,
	input  wire logic              supply_alarm_disable_i,
	input  wire logic [RES_W-1:0]  upper_threshold_i,
	input  wire logic [RES_W-1:0]  lower_threshold_i,
	input  wire logic [HW-1:0]     hysteresis_i,
	input  wire logic [1:0]        output_format_control_i,
	input  wire logic              alarm_read_i,
	output logic                   primary_serial_out_o,
	output logic                   primary_serial_oe_o,
	output logic                   secondary_serial_out_o,
	output logic                   secondary_serial_oe_o,
	output logic                   sample_o,
	output logic                   ready_o,
	output logic      [WORD_W-1:0] cmd_word_o,
	output logic                   cmd_valid_o,
	output logic      [FLAG_W-1:0] alarm_flags_o
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam int SW = RES_W + 2;
	localparam logic signed [SW-1:0] ONE_S = SW'(1);

	aaci_state_type state_ff;
	aaci_state_type nxt_state;

	logic [PIN_N-1:0] pin_raw;
	logic [PIN_N-1:0] pin_s1_ff;
	logic [PIN_N-1:0] pin_s2_ff;
	logic [PIN_N-1:0] pin_s3_ff;
	logic [PIN_N-1:0] pin_f_ff;
	logic             cs_f;

	logic [FLAG_W-1:0] flags_ff;
	logic [FLAG_W-1:0] nxt_flags;
	logic [RES_W-1:0]  result_ff;
	logic [WORD_W-1:0] tx_word_ff;
	logic [WORD_W-1:0] cmd_word_ff;
	logic              cmd_valid_ff;
	logic              sample_ff;
	logic              read_pend_ff;
	logic              frame_reads_ff;
	logic              pin_alarm_ff;

	logic [WORD_W-1:0] link_word;
	logic [CNT_W-1:0]  link_cnt;

	logic              done;
	logic              frame_start;
	logic              frame_end;
	logic              alarm_on;
	logic              in_en;
	logic              sup_en;
	logic signed [SW-1:0] code_s;
	logic signed [SW-1:0] hi_clr_s;
	logic signed [SW-1:0] lo_clr_s;
	logic              in_hi;
	logic              in_lo;
	logic              sup_hi;
	logic              sup_lo;
	logic [FLAG_W-1:0] app_mask;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	assign pin_raw[PIN_CS]    = convert_start_select_i;
	assign pin_raw[PIN_OVER]  = supply_over_i;
	assign pin_raw[PIN_UNDER] = supply_under_i;

	// Filter accepts a change only once stages two and three agree
	for (genvar g = 0; g < PIN_N; g++) begin : g_sync
		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				pin_s1_ff[g] <= PIN_RST[g];
				pin_s2_ff[g] <= PIN_RST[g];
				pin_s3_ff[g] <= PIN_RST[g];
				pin_f_ff[g]  <= PIN_RST[g];
			end else begin
				pin_s1_ff[g] <= pin_raw[g];
				pin_s2_ff[g] <= pin_s1_ff[g];
				pin_s3_ff[g] <= pin_s2_ff[g];
				if (pin_s2_ff[g] == pin_s3_ff[g]) begin
					pin_f_ff[g] <= pin_s3_ff[g];
				end
			end
		end
	end

	assign cs_f = pin_f_ff[PIN_CS];

	// ----------------------------------------
	// Serial link, on the host's clock
	// ----------------------------------------
	// Load word is held still from conversion end to frame end
	aaci_link u_link (
		.sclk_i       (sclk_i),
		.rst_i        (rst_i),
		.cs_i         (convert_start_select_i),
		.sdi_i        (sdi_i),
		.load_word_i  (tx_word_ff),
		.shift_word_o (link_word),
		.bit_count_o  (link_cnt),
		.serial_o     (primary_serial_out_o),
		.serial_oe_o  (primary_serial_oe_o)
	);

	// ----------------------------------------
	// Acquire / frame / convert sequence
	// ----------------------------------------
	assign frame_start = (state_ff == ST_ACQ) && !cs_f;
	assign frame_end   = (state_ff == ST_FRAME) && cs_f;
	assign done        = (state_ff == ST_CONV) && conv_done_i;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_ACQ: begin
				if (!cs_f) begin
					nxt_state = ST_FRAME;
				end
			end
			ST_FRAME: begin
				if (cs_f) begin
					nxt_state = ST_CONV;
				end
			end
			// Select edges are ignored until the result lands
			ST_CONV: begin
				if (conv_done_i) begin
					nxt_state = ST_LOAD;
				end
			end
			ST_LOAD: begin
				nxt_state = ST_ACQ;
			end
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= ST_ACQ;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sample_ff <= 1'b0;
		end else begin
			sample_ff <= frame_end;
		end
	end

	// ----------------------------------------
	// Command capture at frame end
	// ----------------------------------------
	// Short frames are a no-op; sclk is quiet after select rises
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_word_ff  <= WORD_RST;
			cmd_valid_ff <= 1'b0;
		end else begin
			cmd_valid_ff <= frame_end && (link_cnt >= FULL_FRAME);
			if (frame_end) begin
				cmd_word_ff <= link_word;
			end
		end
	end

	// ----------------------------------------
	// Result capture
	// ----------------------------------------
	// Converter code already runs from zero at negative full scale
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			result_ff <= RESULT_RST;
		end else if (done) begin
			result_ff <= conv_result_i;
		end
	end

	// ----------------------------------------
	// Alarm evaluation
	// ----------------------------------------
	assign alarm_on = secondary_output_function_i == FN_ALARM;
	assign in_en    = alarm_on && !input_alarm_disable_i;
	assign sup_en   = alarm_on && !supply_alarm_disable_i;

	// Signed compare so thresholds near zero never wrap
	assign code_s   = $signed({2'b00, conv_result_i});
	assign hi_clr_s = $signed({2'b00, upper_threshold_i})
		- $signed(SW'(hysteresis_i)) - ONE_S;
	assign lo_clr_s = $signed({2'b00, lower_threshold_i})
		+ $signed(SW'(hysteresis_i)) + ONE_S;

	always_comb begin
		if (flags_ff[FL_IN_HI]) begin
			in_hi = in_en && (code_s > hi_clr_s);
		end else begin
			in_hi = in_en && (conv_result_i > upper_threshold_i);
		end
		if (flags_ff[FL_IN_LO]) begin
			in_lo = in_en && (code_s < lo_clr_s);
		end else begin
			in_lo = in_en && (conv_result_i < lower_threshold_i);
		end
	end

	assign sup_hi = sup_en && pin_f_ff[PIN_OVER];
	assign sup_lo = sup_en && pin_f_ff[PIN_UNDER];

	// ----------------------------------------
	// Flag register
	// ----------------------------------------
	// A new trip at conversion end beats a read clear
	always_comb begin
		nxt_flags = flags_ff;
		if (frame_end && frame_reads_ff) begin
			nxt_flags[FL_IN_TRIP]  = 1'b0;
			nxt_flags[FL_SUP_TRIP] = 1'b0;
		end
		if (done) begin
			nxt_flags[FL_IN_HI]   = in_hi;
			nxt_flags[FL_IN_LO]   = in_lo;
			nxt_flags[FL_SUP_HI]  = sup_hi;
			nxt_flags[FL_SUP_LO]  = sup_lo;
			nxt_flags[FL_IN_ACT]  = in_hi | in_lo;
			nxt_flags[FL_SUP_ACT] = sup_hi | sup_lo;
			if (in_hi | in_lo) begin
				nxt_flags[FL_IN_TRIP] = 1'b1;
			end
			if (sup_hi | sup_lo) begin
				nxt_flags[FL_SUP_TRIP] = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			flags_ff <= FLAGS_RST;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	// ----------------------------------------
	// Alarm register read bookkeeping
	// ----------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			read_pend_ff <= 1'b0;
		end else if (alarm_read_i) begin
			read_pend_ff <= 1'b1;
		end else if (frame_end && frame_reads_ff) begin
			read_pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_reads_ff <= 1'b0;
		end else if (frame_start) begin
			frame_reads_ff <= read_pend_ff;
		end
	end

	// ----------------------------------------
	// Output word composition
	// ----------------------------------------
	// Rebuilt only between result and next frame, so the link
	// domain always sees a still word
	always_comb begin
		app_mask = FLAGS_RST;
		if (output_format_control_i[APP_IN]) begin
			app_mask = app_mask | IN_MASK;
		end
		if (output_format_control_i[APP_SUP]) begin
			app_mask = app_mask | SUP_MASK;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_word_ff <= WORD_RST;
		end else if (state_ff == ST_LOAD) begin
			if (read_pend_ff) begin
				tx_word_ff <= {{(WORD_W-FLAG_W){1'b0}}, flags_ff};
			end else begin
				tx_word_ff <= {result_ff, flags_ff & app_mask,
					{(WORD_W-RES_W-FLAG_W){1'b0}}};
			end
		end
	end

	// ----------------------------------------
	// Multifunction pin
	// ----------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_alarm_ff <= 1'b0;
		end else begin
			pin_alarm_ff <= alarm_on
				&& (flags_ff[FL_IN_ACT] || flags_ff[FL_SUP_ACT]);
		end
	end

	assign secondary_serial_out_o = pin_alarm_ff;
	assign secondary_serial_oe_o  = alarm_on;
	assign sample_o               = sample_ff;
	assign ready_o                = state_ff == ST_ACQ;
	assign cmd_word_o             = cmd_word_ff;
	assign cmd_valid_o            = cmd_valid_ff;
	assign alarm_flags_o          = flags_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_frame_close;
		(state_ff == ST_FRAME) && cs_f;
	endsequence

	sequence s_sample_once;
		sample_o ##1 !sample_o [*3];
	endsequence

	chk_sample_edge: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_frame_close |=> s_sample_once)
		else $error("no single sample pulse after frame end");

	chk_short_nop: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_frame_close and (link_cnt < FULL_FRAME) |=> !cmd_valid_o)
		else $error("short frame produced a command");

	chk_high_set: assert property (@(posedge mclk_i) disable iff (rst_i)
		done && in_en && (conv_result_i > upper_threshold_i)
		|=> alarm_flags_o[FL_IN_HI] && alarm_flags_o[FL_IN_TRIP])
		else $error("high input alarm missed");

	chk_high_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		done && in_en && flags_ff[FL_IN_HI] && (code_s > hi_clr_s)
		|=> alarm_flags_o[FL_IN_HI])
		else $error("high alarm released inside hysteresis");

	chk_low_set: assert property (@(posedge mclk_i) disable iff (rst_i)
		done && in_en && (conv_result_i < lower_threshold_i)
		|=> alarm_flags_o[FL_IN_LO] && alarm_flags_o[FL_IN_ACT])
		else $error("low input alarm missed");

	chk_low_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
		done && flags_ff[FL_IN_LO] && (code_s >= lo_clr_s)
		|=> !alarm_flags_o[FL_IN_LO])
		else $error("low alarm failed to clear");

	chk_active_moment: assert property (@(posedge mclk_i) disable iff (rst_i)
		$changed(alarm_flags_o[FL_SUP_ACT]) |-> $past(done))
		else $error("active flag moved outside conversion end");

	chk_trip_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
		flags_ff[FL_IN_TRIP] && !(frame_end && frame_reads_ff)
		|=> alarm_flags_o[FL_IN_TRIP])
		else $error("tripped flag lost without a read");

	chk_read_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_frame_close and frame_reads_ff
		|=> !alarm_flags_o[FL_SUP_TRIP] ##1 !read_pend_ff || alarm_read_i)
		else $error("alarm read did not clear at frame end");

	chk_pin_alarm: assert property (@(posedge mclk_i) disable iff (rst_i)
		done && sup_en && pin_f_ff[PIN_OVER]
		##1 alarm_on |=> secondary_serial_out_o)
		else $error("alarm pin not raised for supply alarm");

	chk_dis_input: assert property (@(posedge mclk_i) disable iff (rst_i)
		done && input_alarm_disable_i |=> !alarm_flags_o[FL_IN_ACT])
		else $error("disabled input alarm went active");

endmodule
`default_nettype wire

// ===== sim/aaci_host.sv
`timescale 1ns/10ps
`default_nettype none
module aaci_host (
	output logic      sclk_o,
	output logic      select_o,
	output logic      sdi_o,
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i
);
	// ----------------
	// Frame driver
	// ----------------
	initial begin
		sclk_o = 1'b0;
		select_o = 1'b1;
		sdi_o = 1'b0;
	end

	// Clock stands still outside frames
	task automatic frame(input int n, input logic [63:0] tx, output logic [63:0] rx);
		rx = 64'h0;
		select_o = 1'b0;
		#250;
		for (int i = n - 1; i >= 0; i--) begin
			sdi_o = tx[i];
			#62.5;
			// Undriven line reads as inverse of last bit, never as a lucky match
			rx = {rx[62:0], sdo_oe_i ? sdo_i : ~rx[0]};
			sclk_o = 1'b1;
			#62.5;
			sclk_o = 1'b0;
		end
		#250;
		select_o = 1'b1;
		sdi_o = ~sdi_o;
	endtask
endmodule
`default_nettype wire

// ===== sim/tb_adc_alarm_and_chain_interface.sv
`timescale 1ns/10ps
`default_nettype none
module tb_adc_alarm_and_chain_interface
	import aaci_pkg::*;
;
	// ----------------
	// Stimulus and wiring
	// ----------------
	logic        mclk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        done = 1'b0;
	logic [15:0] result = 16'h0000;
	logic        over = 1'b0;
	logic        under = 1'b0;
	logic [1:0]  fn = 2'h1;
	logic        in_dis = 1'b0;
	logic        sup_dis = 1'b0;
	logic [15:0] upper = 16'h8000;
	logic [15:0] lower = 16'h1000;
	logic [3:0]  hyst = 4'h4;
	logic [1:0]  fmt = 2'h3;
	logic        rd = 1'b0;
	wire         sclk;
	wire         sel;
	wire         sdi;
	logic        sdo;
	logic        sdo_oe;
	logic        pin;
	logic        pin_oe;
	logic        sample;
	logic        ready;
	logic [31:0] cmd_word;
	logic        cmd_valid;
	logic [7:0]  flags;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	logic [7:0]  fl = 8'h00;
	logic        ih = 1'b0;
	logic        il = 1'b0;
	logic        clr = 1'b0;
	logic [31:0] word = WORD_RST;
	logic [15:0] res_t [7] = '{16'h8000, 16'h8001, 16'h7ffc, 16'h7ffb, 16'h0fff, 16'h1004, 16'h1005};
	logic [1:0]  sup_t [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};

	always #20 mclk_i = ~mclk_i;

	aaci_core u_dut (
		.mclk_i                      (mclk_i),
		.rst_i                       (rst_i),
		.sclk_i                      (sclk),
		.convert_start_select_i      (sel),
		.sdi_i                       (sdi),
		.conv_done_i                 (done),
		.conv_result_i               (result),
		.supply_over_i               (over),
		.supply_under_i              (under),
		.secondary_output_function_i (fn),
		.input_alarm_disable_i       (in_dis),
		.supply_alarm_disable_i      (sup_dis),
		.upper_threshold_i           (upper),
		.lower_threshold_i           (lower),
		.hysteresis_i                (hyst),
		.output_format_control_i     (fmt),
		.alarm_read_i                (rd),
		.primary_serial_out_o        (sdo),
		.primary_serial_oe_o         (sdo_oe),
		.secondary_serial_out_o      (pin),
		.secondary_serial_oe_o       (pin_oe),
		.sample_o                    (sample),
		.ready_o                     (ready),
		.cmd_word_o                  (cmd_word),
		.cmd_valid_o                 (cmd_valid),
		.alarm_flags_o               (flags)
	);

	aaci_host u_host (
		.sclk_o   (sclk),
		.select_o (sel),
		.sdi_o    (sdi),
		.sdo_i    (sdo),
		.sdo_oe_i (sdo_oe)
	);

	// ----------------
	// Checking and closing
	// ----------------
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic wait_hi(input string what, ref logic s);
		int i;
		i = 0;
		while (s !== 1'b1) begin
			@(posedge mclk_i);
			#1;
			i++;
			if (i > 2000) begin
				check(what, 64'h1, 64'h0);
				stop_test();
			end
		end
	endtask

	// Flag model; trips only ever set here, cleared after a read frame
	task automatic model(input logic [15:0] res);
		int  c;
		int  th;
		int  tl;
		int  h;
		logic on;
		c = res;
		th = upper;
		tl = lower;
		h = hyst;
		on = (fn == FN_ALARM);
		if (on && !in_dis) begin
			ih = ih ? (c > th - h - 1) : (c > th);
			il = il ? (c < tl + h + 1) : (c < tl);
		end else begin
			ih = 1'b0;
			il = 1'b0;
		end
		fl[FL_IN_HI] = ih;
		fl[FL_IN_LO] = il;
		fl[FL_SUP_HI] = on && !sup_dis && over;
		fl[FL_SUP_LO] = on && !sup_dis && under;
		fl[FL_IN_ACT] = ih | il;
		fl[FL_SUP_ACT] = fl[FL_SUP_HI] | fl[FL_SUP_LO];
		fl[FL_IN_TRIP] = fl[FL_IN_TRIP] | fl[FL_IN_ACT];
		fl[FL_SUP_TRIP] = fl[FL_SUP_TRIP] | fl[FL_SUP_ACT];
	endtask

	// One frame of n edges, then one conversion giving res
	task automatic conv(input int n, input logic [63:0] tx, input logic [15:0] res, input logic rq);
		logic [63:0] rx;
		logic [63:0] exp;
		logic [7:0]  mask;
		wait_hi("ready", ready);
		u_host.frame(n, tx, rx);
		// Let the enable settle after the select rise
		#1;
		exp = (n <= 32) ? word >> (32 - n) : ({32'h0, word} << (n - 32)) | (tx >> 32);
		check("serial out", exp, rx);
		check("out enable", 64'h0, sdo_oe);
		if (clr) begin
			fl = fl & ~8'h0a;
		end
		wait_hi("sample", sample);
		check("cmd valid", n >= 32, cmd_valid);
		if (n >= 32) begin
			check("cmd word", tx[31:0], cmd_word);
		end
		// Read request inside the conversion, so the next load carries flags
		if (rq) begin
			@(posedge mclk_i);
			rd <= 1'b1;
			@(posedge mclk_i);
			rd <= 1'b0;
		end
		@(posedge mclk_i);
		done <= 1'b1;
		result <= res;
		@(posedge mclk_i);
		done <= 1'b0;
		repeat (3) @(posedge mclk_i);
		#1;
		model(res);
		mask = (fmt[0] ? IN_MASK : 8'h00) | (fmt[1] ? SUP_MASK : 8'h00);
		word = rq ? {24'h0, fl} : {res, fl & mask, 8'h00};
		clr = rq;
		check("alarm flags", fl, flags);
		check("alarm pin", fn == FN_ALARM && (fl[0] | fl[2]), pin);
		check("pin enable", fn == FN_ALARM, pin_oe);
		// Return on an edge so callers change inputs there
		@(posedge mclk_i);
	endtask

	// ----------------
	// Tests
	// ----------------
	initial begin
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		for (int i = 0; i < 7; i++) begin
			over <= sup_t[i][0];
			under <= sup_t[i][1];
			conv(32, 64'hc0de_0000 + i, res_t[i], 1'b0);
		end
		$display("test thresholds done");
		conv(32, 64'h1111_2222, 16'h4000, 1'b1);
		conv(32, 64'h3333_4444, 16'h4000, 1'b0);
		$display("test alarm read done");
		// Single device stands in for a chain; spare bits emerge after the word
		fmt <= 2'h1;
		conv(40, 64'ha5_1234_abcd, 16'h2222, 1'b0);
		conv(8, 64'h5a, 16'h3333, 1'b0);
		$display("test chain done");
		fn <= 2'h0;
		over <= 1'b1;
		conv(32, 64'h0f0f_0f0f, 16'hffff, 1'b0);
		fn <= 2'h1;
		in_dis <= 1'b1;
		sup_dis <= 1'b1;
		conv(32, 64'h5555_aaaa, 16'hffff, 1'b0);
		in_dis <= 1'b0;
		sup_dis <= 1'b0;
		fmt <= 2'h2;
		conv(32, 64'haaaa_5555, 16'hffff, 1'b0);
		conv(32, 64'h7777_8888, 16'h7000, 1'b0);
		$display("test enables done");
		stop_test();
	end
endmodule
`default_nettype wire
